/* rtl/complementary_generator.sv */
// complementary output generator with dead band and auto-shutdown
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module complementary_generator (
	input  wire logic        aclk,                    // clock, 20 MHz
	input  wire logic        aresetn,                 // sync reset, low
	input  wire logic [4:0]  awaddr,                  // write address
	input  wire logic [2:0]  awprot,                  // unused
	input  wire logic        awvalid,                 // write addr valid
	output logic             awready,                 // write addr ready
	input  wire logic [31:0] wdata,                   // write data
	input  wire logic [3:0]  wstrb,                   // byte strobes
	input  wire logic        wvalid,                  // write data valid
	output logic             wready,                  // write data ready
	output logic [1:0]       bresp,                   // write response
	output logic             bvalid,                  // response valid
	input  wire logic        bready,                  // response ready
	input  wire logic [4:0]  araddr,                  // read address
	input  wire logic [2:0]  arprot,                  // unused
	input  wire logic        arvalid,                 // read addr valid
	output logic             arready,                 // read addr ready
	output logic [31:0]      rdata,                   // read data
	output logic [1:0]       rresp,                   // read response
	output logic             rvalid,                  // read data valid
	input  wire logic        rready,                  // read data ready
	input  wire logic        comparator_async_output, // comparator, async
	input  wire logic        fault_input_pin,         // fault, low active
	input  wire logic [2:0]  pwm_in,                  // PWM 1..3 outputs
	output cwg_pkg::pin_t    output_a,                // pin A level/oe
	output cwg_pkg::pin_t    output_b,                // pin B level/oe
	output logic             fast_osc_keep_on         // hold oscillator on
);
	typedef struct packed {
		logic [7:0] con0;
		logic [7:0] con1;
		logic [7:0] con2;
		logic [7:0] dbr;
		logic [7:0] dbf;
		logic       awready;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arready;
		logic       rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic       src_prev;
		logic       hold;
		logic       act_a;
		logic       act_b;
		logic [4:0] acc;
		logic       a_level;
		logic       b_level;
		logic       a_oe;
		logic       b_oe;
		logic       keep;
	} gen_state_t;
	gen_state_t st;
	gen_state_t next_st;

	logic [4:0] pins_s;
	logic       cmp_s;
	logic       flt_n_s;
	logic [2:0] pwm_s;
	logic       src;
	logic       tick;
	logic       shut_sync;
	logic       shut_async;
	logic       rise_go;
	logic       fall_go;
	logic       rise_fire;
	logic       fall_fire;
	logic       wr_go;
	logic       rd_go;
	logic       wr_con2;
	logic       en;
	logic       ovr;
	logic [1:0] lvl_a;
	logic [1:0] lvl_b;
	logic [5:0] acc_sum;

	sync2 #(
		.W (5)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({pwm_in, fault_input_pin, comparator_async_output}),
		.q       (pins_s)
	);
	assign cmp_s   = pins_s[0];
	assign flt_n_s = pins_s[1];
	assign pwm_s   = pins_s[4:2];

	assign en = st.con0[cwg_pkg::B_EN];

	// waveform source, reserved codes give a quiet low
	always_comb begin
		case (st.con1[2:0])
			cwg_pkg::SRC_CMP:  src = cmp_s;
			cwg_pkg::SRC_PWM1: src = pwm_s[0];
			cwg_pkg::SRC_PWM2: src = pwm_s[1];
			cwg_pkg::SRC_PWM3: src = pwm_s[2];
			default:           src = 1'b0;
		endcase
	end

	// shutdown sources, synchronised copy for the status bit
	assign shut_sync =
		(st.con2[cwg_pkg::B_CMPEN] & cmp_s) |
		(st.con2[cwg_pkg::B_FLTEN] & ~flt_n_s);
	// raw pins for the override path, no clock edge needed
	assign shut_async =
		(st.con2[cwg_pkg::B_CMPEN] & comparator_async_output) |
		(st.con2[cwg_pkg::B_FLTEN] & ~fault_input_pin);

	// fast oscillator rate as a fractional enable: 16 ticks per 20 cycles
	// one spare bit so the sum cannot wrap before the compare
	assign acc_sum = {1'b0, st.acc} + {1'b0, cwg_pkg::FAST_OSC_MHZ};
	assign tick = st.con0[cwg_pkg::B_CS] ?
		(acc_sum >= {1'b0, cwg_pkg::SYS_CLK_MHZ}) : 1'b1;

	assign rise_go = en & src & ~st.src_prev & ~st.con2[cwg_pkg::B_ASE]
		& ~shut_sync;
	assign fall_go = en & ~src & st.src_prev & ~st.hold
		& ~st.con2[cwg_pkg::B_ASE];

	deadband_timer #(
		.W (cwg_pkg::DB_W)
	) u_rise (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (rise_go),
		.clr     (fall_go | ~en),
		.tick    (tick),
		.count   (st.dbr[cwg_pkg::DB_W-1:0]),
		.fire    (rise_fire)
	);
	deadband_timer #(
		.W (cwg_pkg::DB_W)
	) u_fall (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (fall_go),
		.clr     (rise_go | ~en),
		.tick    (tick),
		.count   (st.dbf[cwg_pkg::DB_W-1:0]),
		.fire    (fall_fire)
	);

	assign wr_go   = awvalid & st.awready & wvalid & st.awready;
	assign rd_go   = arvalid & st.arready;
	assign wr_con2 = wr_go & wstrb[0] & (awaddr == cwg_pkg::OFF_CON2);

	always_comb begin
		next_st = st;
		// write channel: take address and data together
		if (st.awready)
			next_st.awready = 1'b0;
		else if (awvalid && wvalid && !st.bvalid)
			next_st.awready = 1'b1;
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (wr_go) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = cwg_pkg::RESP_OKAY;
			case (awaddr)
				cwg_pkg::OFF_CON0: if (wstrb[0])
					next_st.con0 = wdata[7:0] & cwg_pkg::CON0_MASK;
				cwg_pkg::OFF_CON1: if (wstrb[0])
					next_st.con1 = wdata[7:0] & cwg_pkg::CON1_MASK;
				cwg_pkg::OFF_CON2: if (wstrb[0]) begin
					next_st.con2[cwg_pkg::B_ARSEN] = wdata[cwg_pkg::B_ARSEN];
					next_st.con2[cwg_pkg::B_CMPEN] = wdata[cwg_pkg::B_CMPEN];
					next_st.con2[cwg_pkg::B_FLTEN] = wdata[cwg_pkg::B_FLTEN];
				end
				cwg_pkg::OFF_DBR: if (wstrb[0])
					next_st.dbr = wdata[7:0] & cwg_pkg::DB_MASK;
				cwg_pkg::OFF_DBF: if (wstrb[0])
					next_st.dbf = wdata[7:0] & cwg_pkg::DB_MASK;
				default: next_st.bresp = cwg_pkg::RESP_SLVERR;
			endcase
		end
		// read channel
		if (st.arready)
			next_st.arready = 1'b0;
		else if (arvalid && !st.rvalid)
			next_st.arready = 1'b1;
		if (st.rvalid && rready)
			next_st.rvalid = 1'b0;
		if (rd_go) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = cwg_pkg::RESP_OKAY;
			case (araddr)
				cwg_pkg::OFF_CON0: next_st.rdata = st.con0;
				cwg_pkg::OFF_CON1: next_st.rdata = st.con1;
				cwg_pkg::OFF_CON2: next_st.rdata = st.con2;
				cwg_pkg::OFF_DBR:  next_st.rdata = st.dbr;
				cwg_pkg::OFF_DBF:  next_st.rdata = st.dbf;
				default: begin
					next_st.rdata = 8'h00;
					next_st.rresp = cwg_pkg::RESP_SLVERR;
				end
			endcase
		end

		// shutdown status: software set, guarded clear, auto clear
		if (wr_con2) begin
			if (wdata[cwg_pkg::B_ASE])
				next_st.con2[cwg_pkg::B_ASE] = 1'b1;
			else if (!st.con2[cwg_pkg::B_ARSEN] && !shut_sync)
				next_st.con2[cwg_pkg::B_ASE] = 1'b0;
		end else if (st.con2[cwg_pkg::B_ARSEN] && !shut_sync) begin
			next_st.con2[cwg_pkg::B_ASE] = 1'b0;
		end
		if (shut_sync)
			next_st.con2[cwg_pkg::B_ASE] = 1'b1;

		// overrides persist until a fresh rising edge
		if (next_st.con2[cwg_pkg::B_ASE])
			next_st.hold = 1'b1;
		else if (rise_go)
			next_st.hold = 1'b0;

		// complementary drive with dead band
		next_st.src_prev = src;
		if (!en || next_st.hold) begin
			next_st.act_a = 1'b0;
			next_st.act_b = 1'b0;
		end else begin
			if (rise_go)
				next_st.act_b = 1'b0;
			else if (fall_fire)
				next_st.act_b = 1'b1;
			if (fall_go)
				next_st.act_a = 1'b0;
			else if (rise_fire)
				next_st.act_a = 1'b1;
		end
		next_st.acc = (st.con0[cwg_pkg::B_CS] && tick) ?
			5'(acc_sum - {1'b0, cwg_pkg::SYS_CLK_MHZ}) :
			(st.con0[cwg_pkg::B_CS] ? acc_sum[4:0] : 5'h00);

		next_st.a_level = next_st.act_a ^ next_st.con0[cwg_pkg::B_POLA];
		next_st.b_level = next_st.act_b ^ next_st.con0[cwg_pkg::B_POLB];
		next_st.a_oe = next_st.con0[cwg_pkg::B_EN]
			& next_st.con0[cwg_pkg::B_OEA];
		next_st.b_oe = next_st.con0[cwg_pkg::B_EN]
			& next_st.con0[cwg_pkg::B_OEB];
		next_st.keep = next_st.con0[cwg_pkg::B_EN]
			& next_st.con0[cwg_pkg::B_CS];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
			st.con0 <= cwg_pkg::RST_REG;
			st.con1 <= cwg_pkg::RST_REG;
			st.con2 <= cwg_pkg::RST_REG;
			st.dbr <= cwg_pkg::RST_REG;
			st.dbf <= cwg_pkg::RST_REG;
		end else begin
			st <= next_st;
		end
	end

	// override mux sits after the flops so a fault needs no clock
	assign ovr = en & (st.hold | shut_async);
	assign lvl_a = st.con1[cwg_pkg::LVLA_LSB +: 2];
	assign lvl_b = st.con1[cwg_pkg::LVLB_LSB +: 2];

	always_comb begin
		output_a.level = st.a_level;
		output_a.oe = st.a_oe;
		output_b.level = st.b_level;
		output_b.oe = st.b_oe;
		if (ovr) begin
			case (lvl_a)
				cwg_pkg::LVL_HIGH: output_a.level = 1'b1;
				cwg_pkg::LVL_LOW:  output_a.level = 1'b0;
				cwg_pkg::LVL_REL:  output_a.oe = 1'b0;
				default:  output_a.level = st.con0[cwg_pkg::B_POLA];
			endcase
			case (lvl_b)
				cwg_pkg::LVL_HIGH: output_b.level = 1'b1;
				cwg_pkg::LVL_LOW:  output_b.level = 1'b0;
				cwg_pkg::LVL_REL:  output_b.oe = 1'b0;
				default:  output_b.level = st.con0[cwg_pkg::B_POLB];
			endcase
		end
	end

	assign awready = st.awready;
	assign wready  = st.awready;
	assign bvalid  = st.bvalid;
	assign bresp   = st.bresp;
	assign arready = st.arready;
	assign rvalid  = st.rvalid;
	assign rresp   = st.rresp;
	assign rdata   = {24'h000000, st.rdata};
	assign fast_osc_keep_on = st.keep;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_rise_now;
		rise_go && !st.con0[cwg_pkg::B_CS] && st.dbr == 8'h00;
	endsequence
	sequence s_quiet;
		!fall_go;
	endsequence

	property p_cmp_sd;
		st.con2[cwg_pkg::B_CMPEN] && cmp_s |=> st.con2[cwg_pkg::B_ASE];
	endproperty
	a_cmp_sd: assert property (p_cmp_sd)
		else $error("comparator shutdown not taken");
	property p_flt_sd;
		st.con2[cwg_pkg::B_FLTEN] && !flt_n_s |=> st.con2[cwg_pkg::B_ASE];
	endproperty
	a_flt_sd: assert property (p_flt_sd)
		else $error("fault pin shutdown not taken");
	property p_ovr_now;
		en && shut_async && lvl_a == cwg_pkg::LVL_HIGH
			|-> output_a.level;
	endproperty
	a_ovr_now: assert property (p_ovr_now)
		else $error("override A not applied at once");
	property p_level;
		shut_sync [*2] |-> st.con2[cwg_pkg::B_ASE];
	endproperty
	a_level: assert property (p_level)
		else $error("shutdown left while source active");
	property p_read_ase;
		rd_go && araddr == cwg_pkg::OFF_CON2
			|=> rdata[cwg_pkg::B_ASE] == $past(st.con2[cwg_pkg::B_ASE]);
	endproperty
	a_read_ase: assert property (p_read_ase)
		else $error("status read does not match state");
	property p_sw_clear;
		wr_con2 && !wdata[cwg_pkg::B_ASE] && shut_sync
			|=> st.con2[cwg_pkg::B_ASE];
	endproperty
	a_sw_clear: assert property (p_sw_clear)
		else $error("status cleared while source active");
	property p_auto;
		st.con2[cwg_pkg::B_ARSEN] && !shut_sync && !wr_con2
			|=> !st.con2[cwg_pkg::B_ASE];
	endproperty
	a_auto: assert property (p_auto)
		else $error("auto restart did not clear status");
	property p_hold;
		st.hold && !rise_go |=> st.hold;
	endproperty
	a_hold: assert property (p_hold)
		else $error("override released without rising edge");
	property p_off;
		!en |-> !output_a.oe && !output_b.oe;
	endproperty
	a_off: assert property (p_off)
		else $error("pin driven while disabled");
	property p_rise;
		s_rise_now ##1 s_quiet |=> st.act_a;
	endproperty
	a_rise: assert property (p_rise)
		else $error("A not on after zero dead band");
	property p_b_off;
		rise_go |=> !st.act_b ##1 !st.act_b;
	endproperty
	a_b_off: assert property (p_b_off)
		else $error("B not turned off on rising edge");
endmodule
`default_nettype wire

/* rtl/deadband_timer.sv */
// one dead-band counter with a single-cycle fire pulse
`timescale 1ns/1ps
`default_nettype none
module deadband_timer #(
	parameter int W = cwg_pkg::DB_W
) (
	input  wire logic         aclk,    // clock
	input  wire logic         aresetn, // sync reset, low
	input  wire logic         start,   // input edge seen
	input  wire logic         clr,     // abort a running count
	input  wire logic         tick,    // dead-band clock enable
	input  wire logic [W-1:0] count,   // dead-band length in ticks
	output logic              fire     // count reached, one cycle
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         busy;
		logic         fire;
	} timer_state_t;
	timer_state_t st;
	timer_state_t next_st;
	always_comb begin
		next_st = st;
		next_st.fire = 1'b0;
		if (clr) begin
			next_st.busy = 1'b0;
		end else if (start) begin
			if (count == '0) begin
				next_st.fire = 1'b1;
				next_st.busy = 1'b0;
			end else begin
				next_st.cnt = count;
				next_st.busy = 1'b1;
			end
		end else if (st.busy && tick) begin
			if (st.cnt == W'(1)) begin
				next_st.fire = 1'b1;
				next_st.busy = 1'b0;
			end
			next_st.cnt = st.cnt - W'(1);
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end
	assign fire = st.fire;
endmodule
`default_nettype wire

/* rtl/sync2.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         aclk,    // clock
	input  wire logic         aresetn, // sync reset, low
	input  wire logic [W-1:0] d,       // asynchronous inputs
	output logic      [W-1:0] q        // synchronised inputs
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;
	sync_state_t st;
	sync_state_t next_st;
	always_comb begin
		next_st.s1 = d;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			st <= '0;
		else
			st <= next_st;
	end
	assign q = st.s2;
endmodule
`default_nettype wire

/* shared/cwg_pkg.sv */
// constants and carrier types for the complementary waveform generator
// Operation
// - comparator shutdown enable: comparator high forces shutdown.
// - fault pin shutdown enable: fault pin low forces shutdown.
// - active enabled shutdown input drives override levels at once.
// - shutdown inputs are levels; shutdown holds while one stays active.
// - shutdown status bit reads 1 while a shutdown is in effect.
// - software writing 1 to shutdown status forces shutdown.
// - auto-restart enable picks automatic or software restart.
// - software clear of status works only with shutdown inputs inactive.
// - with auto-restart, hardware clears status once sources go inactive.
// - overrides stay until next rising input edge after status clears.
// - B override: 11 high, 10 low, 01 released, 00 inactive level.
// - A override uses the same encoding as B.
// - source select: 000 comparator, 010/011/100 PWM 1-3, others reserved.
// - module enable bit turns the block on; resets to 0.
// - output enable bits hand each pin to the block.
// - polarity bits invert the active waveform of each output.
// - clock select: 1 fast oscillator rate, 0 system clock.
// - keeps running in sleep while its clock and source run.
// - fast oscillator kept on when enabled and selected.
// - rising edge: B off at once, A on after rising dead band.
// - falling edge: A off at once, B on after falling dead band.
package cwg_pkg;
	localparam int        ADDR_W      = 5;
	localparam int        DB_W        = 6;
	localparam logic [4:0] OFF_CON0   = 5'h00;
	localparam logic [4:0] OFF_CON1   = 5'h04;
	localparam logic [4:0] OFF_CON2   = 5'h08;
	localparam logic [4:0] OFF_DBR    = 5'h0C;
	localparam logic [4:0] OFF_DBF    = 5'h10;
	localparam int        B_EN        = 7;
	localparam int        B_OEB       = 6;
	localparam int        B_OEA       = 5;
	localparam int        B_POLB      = 4;
	localparam int        B_POLA      = 3;
	localparam int        B_CS        = 0;
	localparam int        B_ASE       = 7;
	localparam int        B_ARSEN     = 6;
	localparam int        B_CMPEN     = 2;
	localparam int        B_FLTEN     = 1;
	localparam int        LVLB_LSB    = 6;
	localparam int        LVLA_LSB    = 4;
	localparam logic [7:0] CON0_MASK  = 8'hF9;
	localparam logic [7:0] CON1_MASK  = 8'hF7;
	localparam logic [7:0] CON2_MASK  = 8'hC6;
	localparam logic [7:0] DB_MASK    = 8'h3F;
	localparam logic [7:0] RST_REG    = 8'h00;
	localparam logic [1:0] LVL_HIGH   = 2'h3;
	localparam logic [1:0] LVL_LOW    = 2'h2;
	localparam logic [1:0] LVL_REL    = 2'h1;
	localparam logic [2:0] SRC_CMP    = 3'h0;
	localparam logic [2:0] SRC_PWM1   = 3'h2;
	localparam logic [2:0] SRC_PWM2   = 3'h3;
	localparam logic [2:0] SRC_PWM3   = 3'h4;
	localparam logic [4:0] SYS_CLK_MHZ  = 5'h14;
	localparam logic [4:0] FAST_OSC_MHZ = 5'h10;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic level;
		logic oe;
	} pin_t;
endpackage

/* tb/complementary_generator_test.sv */
// self-checking bench for the complementary waveform generator
`timescale 1ns/1ps
`default_nettype none
module complementary_generator_test;
	localparam logic [1:0] OK = cwg_pkg::RESP_OKAY;
	localparam logic [1:0] SE = cwg_pkg::RESP_SLVERR;
	typedef struct packed {
		logic [4:0] v;
		logic [4:0] m;
	} pin_note_t;
	logic          aclk = 1'b0;
	logic          aresetn = 1'b0;
	logic [4:0]    awaddr = 5'h00;
	logic [4:0]    araddr = 5'h00;
	logic [31:0]   wdata = 32'h0;
	logic          awvalid = 1'b0;
	logic          wvalid = 1'b0;
	logic          bready = 1'b0;
	logic          arvalid = 1'b0;
	logic          rready = 1'b0;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [1:0]    bresp, rresp;
	logic [31:0]   rdata;
	logic          cmp, flt_n, keep;
	logic [2:0]    pwm;
	logic          slow = 1'b0;
	logic          cmp_set = 1'b0;
	logic          flt_set = 1'b0;
	logic [2:0]    pwm_set = 3'h0;
	cwg_pkg::pin_t output_a, output_b;
	logic [33:0]   bus_q [$];
	pin_note_t     pin_q [$];
	pin_note_t     pn;
	event          pin_ev;
	int            err_total = 0;
	int            checks = 0;
	logic [7:0]    r;
	logic [4:0]    offs [5] = '{cwg_pkg::OFF_CON0, cwg_pkg::OFF_CON1,
		cwg_pkg::OFF_CON2, cwg_pkg::OFF_DBR, cwg_pkg::OFF_DBF};
	logic [7:0]    msk [5] = '{cwg_pkg::CON0_MASK, cwg_pkg::CON1_MASK,
		cwg_pkg::CON2_MASK, cwg_pkg::DB_MASK, cwg_pkg::DB_MASK};
	logic [2:0]    srcs [4] = '{cwg_pkg::SRC_CMP, cwg_pkg::SRC_PWM1,
		cwg_pkg::SRC_PWM2, cwg_pkg::SRC_PWM3};

	always #25 aclk = ~aclk;

	complementary_generator dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.comparator_async_output(cmp), .fault_input_pin(flt_n),
		.pwm_in(pwm), .output_a(output_a), .output_b(output_b),
		.fast_osc_keep_on(keep)
	);

	switch_side_model far (
		.aclk(aclk), .slow(slow), .cmp_set(cmp_set), .flt_set(flt_set),
		.pwm_set(pwm_set), .cmp_out(cmp), .flt_n(flt_n), .pwm_out(pwm)
	);

	task automatic check(input string what, input logic [33:0] seen,
		input logic [33:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// results are compared in the order they were noted
	always @(posedge aclk) begin
		if (bvalid && bready)
			check("bresp", {32'h0, bresp}, bus_q.pop_front());
		if (rvalid && rready)
			check("read", {rresp, rdata}, bus_q.pop_front());
	end

	always @(pin_ev) begin
		pn = pin_q.pop_front();
		check("pins", {29'h0, {output_a, output_b, keep} & pn.m},
			{29'h0, pn.v & pn.m});
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] rs);
		logic a_ok;
		logic d_ok;
		a_ok = 1'b0;
		d_ok = 1'b0;
		bus_q.push_back({32'h0, rs});
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel is released on its own ready
		while (!(a_ok && d_ok)) begin
			@(posedge aclk);
			if (!a_ok && awready === 1'b1) begin
				a_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!d_ok && wready === 1'b1) begin
				d_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] rs);
		bus_q.push_back({rs, 24'h0, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		rready <= 1'b0;
	endtask

	// pin order: a.level a.oe b.level b.oe keep
	task automatic pins(input logic [4:0] v, input logic [4:0] m);
		@(negedge aclk);
		pin_q.push_back({v, m});
		-> pin_ev;
	endtask

	task automatic drv(input logic c, input logic f, input logic [2:0] p);
		@(posedge aclk);
		cmp_set <= c;
		flt_set <= f;
		pwm_set <= p;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		stop_test();
	end

	initial begin
		void'($urandom(94909));
		cyc(2);
		aresetn <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			r = 8'($urandom);
			if (i == 2)
				r[7] = 1'b0;
			rd(offs[i], 8'h00, OK);
			wr(offs[i], r, OK);
			rd(offs[i], r & msk[i], OK);
			wr(offs[i], 8'h00, OK);
		end
		wr(5'h14, 8'hFF, SE);
		rd(5'h14, 8'h00, SE);
		wr(cwg_pkg::OFF_DBR, 8'h06, OK);
		wr(cwg_pkg::OFF_DBF, 8'h06, OK);
		wr(cwg_pkg::OFF_CON2, 8'h86, OK);
		wr(cwg_pkg::OFF_CON1, 8'hD2, OK);
		wr(cwg_pkg::OFF_CON0, 8'hE0, OK);
		pins(5'b00110, 5'h0F);
		rd(cwg_pkg::OFF_CON2, 8'h86, OK);
		wr(cwg_pkg::OFF_CON2, 8'h06, OK);
		cyc(5);
		pins(5'b00110, 5'h0F);
		drv(1'b0, 1'b0, 3'h1);
		cyc(4);
		pins(5'b01010, 5'h1F);
		cyc(8);
		pins(5'b11010, 5'h1F);
		drv(1'b0, 1'b0, 3'h0);
		cyc(4);
		pins(5'b01010, 5'h1F);
		cyc(8);
		pins(5'b01110, 5'h1F);
		wr(cwg_pkg::OFF_CON0, 8'hF8, OK);
		pins(5'b11010, 5'h1F);
		wr(cwg_pkg::OFF_CON0, 8'h80, OK);
		pins(5'b00000, 5'b01011);
		wr(cwg_pkg::OFF_CON0, 8'h60, OK);
		pins(5'b00000, 5'b01011);
		wr(cwg_pkg::OFF_CON0, 8'hE1, OK);
		cyc(2);
		pins(5'b00001, 5'h01);
		wr(cwg_pkg::OFF_CON0, 8'hE0, OK);
		drv(1'b1, 1'b0, 3'h0);
		pins(5'b00110, 5'h0F);
		cyc(5);
		rd(cwg_pkg::OFF_CON2, 8'h86, OK);
		wr(cwg_pkg::OFF_CON2, 8'h06, OK);
		rd(cwg_pkg::OFF_CON2, 8'h86, OK);
		drv(1'b0, 1'b0, 3'h0);
		cyc(4);
		wr(cwg_pkg::OFF_CON2, 8'h06, OK);
		rd(cwg_pkg::OFF_CON2, 8'h06, OK);
		pins(5'b00110, 5'h0F);
		slow <= 1'b1;
		wr(cwg_pkg::OFF_CON2, 8'h04, OK);
		drv(1'b0, 1'b1, 3'h0);
		cyc(6);
		rd(cwg_pkg::OFF_CON2, 8'h04, OK);
		wr(cwg_pkg::OFF_CON2, 8'h02, OK);
		rd(cwg_pkg::OFF_CON2, 8'h82, OK);
		drv(1'b1, 1'b0, 3'h0);
		cyc(6);
		wr(cwg_pkg::OFF_CON2, 8'h02, OK);
		rd(cwg_pkg::OFF_CON2, 8'h02, OK);
		wr(cwg_pkg::OFF_CON2, 8'h42, OK);
		drv(1'b0, 1'b1, 3'h0);
		cyc(6);
		rd(cwg_pkg::OFF_CON2, 8'hC2, OK);
		drv(1'b0, 1'b0, 3'h0);
		cyc(6);
		rd(cwg_pkg::OFF_CON2, 8'h42, OK);
		slow <= 1'b0;
		wr(cwg_pkg::OFF_CON2, 8'h00, OK);
		for (int i = 0; i < 4; i++) begin
			wr(cwg_pkg::OFF_CON1, {5'b11010, srcs[i]}, OK);
			drv(i == 0, 1'b0, (i == 0) ? 3'h0 : 3'(1 << (i - 1)));
			cyc(12);
			pins(5'b11010, 5'h1F);
			drv(1'b0, 1'b0, 3'h0);
			cyc(12);
			pins(5'b01110, 5'h1F);
		end
		// reserved source, zero dead band, low and inactive overrides
		wr(cwg_pkg::OFF_DBR, 8'h00, OK);
		wr(cwg_pkg::OFF_CON0, 8'hF0, OK);
		wr(cwg_pkg::OFF_CON1, 8'h85, OK);
		drv(1'b0, 1'b0, 3'h7);
		cyc(12);
		pins(5'b01010, 5'h1F);
		wr(cwg_pkg::OFF_CON1, 8'h82, OK);
		cyc(2);
		pins(5'b11110, 5'h1F);
		wr(cwg_pkg::OFF_CON2, 8'h80, OK);
		pins(5'b01010, 5'h1F);
		wr(cwg_pkg::OFF_CON2, 8'h00, OK);
		// fractional dead-band clock
		wr(cwg_pkg::OFF_CON0, 8'hF1, OK);
		drv(1'b0, 1'b0, 3'h0);
		cyc(4);
		drv(1'b0, 1'b0, 3'h1);
		cyc(6);
		pins(5'b11111, 5'h1F);
		drv(1'b0, 1'b0, 3'h0);
		cyc(4);
		pins(5'b01111, 5'h1F);
		cyc(10);
		pins(5'b01011, 5'h1F);
		cyc(2);
		stop_test();
	end
endmodule
`default_nettype wire

/* tb/switch_side_model.sv */
// far-side model: comparator, fault sensor and PWM sources
`timescale 1ns/1ps
`default_nettype none
module switch_side_model (
	input  wire logic       aclk,    // clock
	input  wire logic       slow,    // answer one cycle late
	input  wire logic       cmp_set, // comparator trip request
	input  wire logic       flt_set, // fault request
	input  wire logic [2:0] pwm_set, // PWM source levels
	output logic            cmp_out, // comparator output
	output logic            flt_n,   // fault pin, low active
	output logic      [2:0] pwm_out  // PWM outputs
);
	logic [4:0] late;

	always_ff @(posedge aclk) begin
		late <= {cmp_set, flt_set, pwm_set};
	end

	// sensor outputs are levels, never pulses
	always_comb begin
		cmp_out = slow ? late[4] : cmp_set;
		flt_n   = ~(slow ? late[3] : flt_set);
		pwm_out = slow ? late[2:0] : pwm_set;
	end
endmodule
`default_nettype wire
